/* inc/pocc_pkg.sv */
// package for the port power / over-current configuration block
// assumes an apb slave on a 20 mhz clock, three downstream ports
package pocc_pkg;

  // ----------------------------------------
  // address map: register index, byte address = 4 * index
  // ----------------------------------------
  localparam int          ADDR_W   = 17;
  localparam int          IDX_W    = 15;
  localparam logic [14:0] IDX_PWR3 = 15'h3c08;
  localparam logic [14:0] IDX_OVC1 = 15'h3c20;
  localparam logic [14:0] IDX_OVC2 = 15'h3c24;
  localparam logic [14:0] IDX_OVC3 = 15'h3c28;
  localparam logic [14:0] IDX_CDP  = 15'h5246;
  localparam logic [14:0] IDX_GANG = 15'h525a;
  localparam logic [14:0] IDX_PIN  = 15'h525b;
  localparam logic [14:0] IDX_STAT = 15'h5300;
  localparam logic [14:0] IDX_MASK = 15'h5301;

  // ----------------------------------------
  // field layouts
  // ----------------------------------------
  typedef struct packed {
    logic       combined;
    logic       rsv;
    logic       disabled;
    logic       fixed_attached_device;
    logic [3:0] power_source_code;
  } pocc_pwr_sel_t;

  typedef struct packed {
    logic [2:0] overcurrent_sense;
    logic [2:0] overcurrent_gpio;
    logic [2:0] charge_handshake;
  } pocc_sense_t;

  localparam int JOIN_LSB     = 1;
  localparam int PIN_W        = 6;
  localparam int STAT_OC_LSB  = 0;
  localparam int STAT_CDP_LSB = 3;
  localparam int STAT_W       = 6;

  // ----------------------------------------
  // codes and reset values
  // ----------------------------------------
  localparam logic [3:0] PWR_OFF    = 4'h0;
  localparam logic [3:0] PWR_USB2   = 4'h1;
  localparam logic [3:0] PWR_USB3   = 4'h2;
  localparam logic [3:0] PWR_EITHER = 4'h3;
  localparam logic [3:0] PWR_GPIO   = 4'h4;
  localparam logic [3:0] OC_OFF     = 4'h0;
  localparam logic [3:0] OC_PIN     = 4'h1;
  localparam logic [3:0] OC_GPIO    = 4'h2;
  localparam logic [3:0] OC_FORCE   = 4'hf;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [5:0] RST_PIN    = 6'h01;
  localparam logic [5:0] RST_STAT   = 6'h00;

endpackage

/* rtl/pocc_regs.sv */
// port power and over-current source configuration with apb registers
// assumes apb master on clk, all pin inputs synchronous to clk
//
// Operation
// - Power select bit 7 clear keeps power and over-current on separate pins, set shares one pin.
// - Power select bit 5 set marks the port permanently disabled.
// - Power select bit 4 set marks the port as holding a non-removable device.
// - Power source code 0000b keeps port power off.
// - Codes 0001b, 0010b, 0011b turn power on from usb2, usb3 or either port power.
// - Code 0100b makes port power follow a general-purpose input; other codes are reserved.
// - Over-current source code 0000b disables the port.
// - Over-current code 0001b takes the indication from the port's dedicated pin.
// - Over-current code 0010b takes the indication from a general-purpose input.
// - Over-current code 1111b forces the indication active for test.
// - Each port has a flag set when a charging handshake was seen before enumeration.
// - Gang bit 3 joins port 3 over-current onto the selected shared pin.
// - Gang bits 2 and 1 join port 2 and port 1 over-current onto the shared pin.
// - A 6-bit field picks the shared pin and only listed codes are valid.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module pocc_regs #(
  parameter int PORTS = 3
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [pocc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      usb2_power_on,
  input  wire logic                      usb3_power_on,
  input  wire logic                      power_gpio,
  input  wire pocc_pkg::pocc_sense_t     sense,
  input  wire logic                      port3_power_in,
  output logic                           port3_power_out,
  output logic                           port3_power_oe,
  output logic                           port3_power_on,
  output logic                           port3_fixed_device,
  output logic      [PORTS-1:0]          port_overcurrent,
  output logic      [PORTS-1:0]          port_disabled,
  output logic                           joined_overcurrent,
  output logic                           joined_valid,
  output logic      [pocc_pkg::PIN_W-1:0] joined_pin,
  output logic                           irq
);

  if (PORTS != 3) begin : g_chk
    $error("pocc_regs serves exactly three ports");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  pocc_pkg::pocc_pwr_sel_t          pwr3_q;
  logic [7:0]                       ovc_q [PORTS];
  logic [7:0]                       cdp_q;
  logic [7:0]                       gang_q;
  logic [pocc_pkg::PIN_W-1:0]       pin_q;
  logic [pocc_pkg::STAT_W-1:0]      stat_q;
  logic [pocc_pkg::STAT_W-1:0]      mask_q;
  logic [PORTS-1:0]                 oc_q;
  logic [PORTS-1:0]                 oc_d;
  logic [PORTS-1:0]                 dis_q;
  logic [PORTS-1:0]                 dis_d;
  logic                             pwr_on_q;
  logic                             pwr_on_d;
  logic                             pready_q;
  logic                             pslverr_q;
  logic [31:0]                      prdata_q;
  logic                             joined_q;
  logic                             jvalid_q;
  logic                             jvalid_d;
  logic                             irq_q;
  logic                             fixed_q;
  logic                             pout_q;
  logic                             poe_q;

  // ----------------------------------------
  // apb slave: one wait state, answer in the second access cycle
  // ----------------------------------------
  logic [pocc_pkg::IDX_W-1:0] idx;
  logic                       acc;
  logic                       wr;
  logic                       hit;
  logic [31:0]                rd_d;

  assign idx = paddr[pocc_pkg::ADDR_W-1:2];
  assign acc = psel & penable & ~pready_q;
  assign wr  = psel & penable & pwrite & pready_q & ~pslverr_q;

  // read mux and address decode
  always_comb begin
    rd_d = 32'h0000_0000;
    hit  = 1'b1;
    unique case (idx)
      pocc_pkg::IDX_PWR3: rd_d[7:0] = {pwr3_q.combined, 1'b0, pwr3_q[5:0]};
      pocc_pkg::IDX_OVC1: rd_d[7:0] = ovc_q[0];
      pocc_pkg::IDX_OVC2: rd_d[7:0] = ovc_q[1];
      pocc_pkg::IDX_OVC3: rd_d[7:0] = ovc_q[2];
      pocc_pkg::IDX_CDP:  rd_d[7:0] = cdp_q;
      pocc_pkg::IDX_GANG: rd_d[7:0] = gang_q;
      pocc_pkg::IDX_PIN:  rd_d[pocc_pkg::PIN_W-1:0] = pin_q;
      pocc_pkg::IDX_STAT: rd_d[pocc_pkg::STAT_W-1:0] = stat_q;
      pocc_pkg::IDX_MASK: rd_d[pocc_pkg::STAT_W-1:0] = mask_q;
      default:            hit = 1'b0;
    endcase
  end

  // handshake outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc & ~hit;
      if (acc) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // port 3 power select, reserved bit 6 stays zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwr3_q <= pocc_pkg::RST_BYTE;
    end else if (wr && idx == pocc_pkg::IDX_PWR3) begin
      pwr3_q <= {pwdata[7], 1'b0, pwdata[5:0]};
    end
  end

  // over-current select per port
  for (genvar i = 0; i < PORTS; i++) begin : g_ovc
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        ovc_q[i] <= pocc_pkg::RST_BYTE;
      end else if (wr && idx == pocc_pkg::IDX_OVC1 + 15'(4 * i)) begin
        ovc_q[i] <= pwdata[7:0];
      end
    end
  end

  // handshake flags: hardware set wins over a software write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cdp_q <= pocc_pkg::RST_BYTE;
    end else begin
      cdp_q <= ((wr && idx == pocc_pkg::IDX_CDP) ? pwdata[7:0] : cdp_q)
             | {5'h00, sense.charge_handshake};
    end
  end

  // gang control and shared pin choice
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gang_q <= pocc_pkg::RST_BYTE;
      pin_q  <= pocc_pkg::RST_PIN;
    end else begin
      if (wr && idx == pocc_pkg::IDX_GANG) begin
        gang_q <= pwdata[7:0];
      end
      if (wr && idx == pocc_pkg::IDX_PIN) begin
        pin_q <= pwdata[pocc_pkg::PIN_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // port 3 power source
  // ----------------------------------------
  always_comb begin
    unique case (pwr3_q.power_source_code)
      pocc_pkg::PWR_OFF:    pwr_on_d = 1'b0;
      pocc_pkg::PWR_USB2:   pwr_on_d = usb2_power_on;
      pocc_pkg::PWR_USB3:   pwr_on_d = usb3_power_on;
      pocc_pkg::PWR_EITHER: pwr_on_d = usb2_power_on | usb3_power_on;
      pocc_pkg::PWR_GPIO:   pwr_on_d = power_gpio;
      default:              pwr_on_d = 1'b0;
    endcase
    if (pwr3_q.disabled) begin
      pwr_on_d = 1'b0;
    end
  end

  // power pin: push-pull when separate, open drain pulled low for off when shared
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwr_on_q <= 1'b0;
      pout_q   <= 1'b0;
      poe_q    <= 1'b1;
      fixed_q  <= 1'b0;
    end else begin
      pwr_on_q <= pwr_on_d;
      pout_q   <= pwr3_q.combined ? 1'b0 : pwr_on_d;
      poe_q    <= pwr3_q.combined ? ~pwr_on_d : 1'b1;
      fixed_q  <= pwr3_q.fixed_attached_device;
    end
  end

  // ----------------------------------------
  // over-current source per port
  // ----------------------------------------
  for (genvar i = 0; i < PORTS; i++) begin : g_oc
    logic pin_src;
    logic last;
    assign last = (i == PORTS - 1);
    // shared pin reads low while the switch reports a fault
    assign pin_src = (last && pwr3_q.combined) ? (pwr_on_q & ~port3_power_in)
                                               : sense.overcurrent_sense[i];
    always_comb begin
      dis_d[i] = 1'b0;
      unique case (ovc_q[i][3:0])
        pocc_pkg::OC_OFF: begin
          oc_d[i]  = 1'b0;
          dis_d[i] = 1'b1;
        end
        pocc_pkg::OC_PIN:   oc_d[i] = pin_src;
        pocc_pkg::OC_GPIO:  oc_d[i] = sense.overcurrent_gpio[i];
        pocc_pkg::OC_FORCE: oc_d[i] = 1'b1;
        default: begin
          oc_d[i]  = 1'b0;
          dis_d[i] = 1'b1;
        end
      endcase
      if (last && pwr3_q.disabled) begin
        oc_d[i]  = 1'b0;
        dis_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oc_q  <= '0;
      dis_q <= '1;
    end else begin
      oc_q  <= oc_d;
      dis_q <= dis_d;
    end
  end

  // ----------------------------------------
  // joined over-current on the shared pin
  // ----------------------------------------
  always_comb begin
    unique case (pin_q)
      6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h06,
      6'h07, 6'h08, 6'h09, 6'h0a, 6'h0f: jvalid_d = 1'b1;
      default:                           jvalid_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      joined_q <= 1'b0;
      jvalid_q <= 1'b0;
    end else begin
      jvalid_q <= jvalid_d;
      joined_q <= jvalid_d & |(oc_d & gang_q[pocc_pkg::JOIN_LSB +: PORTS]);
    end
  end

  // ----------------------------------------
  // interrupt: sticky status, write one to clear, set wins
  // ----------------------------------------
  logic [pocc_pkg::STAT_W-1:0] stat_set;
  logic [pocc_pkg::STAT_W-1:0] stat_clr;
  assign stat_set = {sense.charge_handshake, oc_d & ~oc_q};
  assign stat_clr = (wr && idx == pocc_pkg::IDX_STAT) ? pwdata[pocc_pkg::STAT_W-1:0] : '0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_q <= pocc_pkg::RST_STAT;
      mask_q <= pocc_pkg::RST_STAT;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      if (wr && idx == pocc_pkg::IDX_MASK) begin
        mask_q <= pwdata[pocc_pkg::STAT_W-1:0];
      end
      irq_q <= |(((stat_q & ~stat_clr) | stat_set) & mask_q);
    end
  end

  // output wiring
  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign port3_power_out    = pout_q;
  assign port3_power_oe     = poe_q;
  assign port3_power_on     = pwr_on_q;
  assign port3_fixed_device = fixed_q;
  assign port_overcurrent   = oc_q;
  assign port_disabled      = dis_q;
  assign joined_overcurrent = joined_q;
  assign joined_valid       = jvalid_q;
  assign joined_pin         = pin_q;
  assign irq                = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_wr_pwr3;
    psel && penable && pwrite && pready_q && idx == pocc_pkg::IDX_PWR3;
  endsequence

  property p_pwr_off;
    pwr3_q.power_source_code == pocc_pkg::PWR_OFF |=> !port3_power_on;
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("power on with code zero");

  property p_pwr_usb2;
    pwr3_q.power_source_code == pocc_pkg::PWR_USB2 && !pwr3_q.disabled
      |=> port3_power_on == $past(usb2_power_on);
  endproperty
  a_pwr_usb2: assert property (p_pwr_usb2) else $error("power not following usb2");

  property p_pwr_gpio;
    pwr3_q.power_source_code == pocc_pkg::PWR_GPIO && !pwr3_q.disabled
      |=> port3_power_on == $past(power_gpio);
  endproperty
  a_pwr_gpio: assert property (p_pwr_gpio) else $error("power not following gpio");

  property p_disabled;
    s_wr_pwr3 ##0 pwdata[5] |=> ##1 (!port3_power_on && !port_overcurrent[2] && port_disabled[2]);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled port still active");

  property p_combined;
    pwr3_q.combined |=> !port3_power_out && port3_power_oe == !port3_power_on;
  endproperty
  a_combined: assert property (p_combined) else $error("shared pin driven wrong");

  property p_oc_off;
    ovc_q[0][3:0] == pocc_pkg::OC_OFF |=> !port_overcurrent[0] && port_disabled[0];
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("port one over-current not disabled");

  property p_oc_pin;
    ovc_q[1][3:0] == pocc_pkg::OC_PIN |=> port_overcurrent[1] == $past(sense.overcurrent_sense[1]);
  endproperty
  a_oc_pin: assert property (p_oc_pin) else $error("port two not from its pin");

  property p_oc_force;
    ovc_q[0][3:0] == pocc_pkg::OC_FORCE [*2] |-> port_overcurrent[0];
  endproperty
  a_oc_force: assert property (p_oc_force) else $error("forced over-current missing");

  property p_cdp;
    sense.charge_handshake[0] |=> cdp_q[0] && stat_q[pocc_pkg::STAT_CDP_LSB];
  endproperty
  a_cdp: assert property (p_cdp) else $error("handshake flag lost");

  property p_join3;
    gang_q[3] && jvalid_d && oc_d[2] |=> joined_overcurrent;
  endproperty
  a_join3: assert property (p_join3) else $error("port three not joined");

  property p_join_bad;
    !jvalid_d |=> !joined_overcurrent && !joined_valid;
  endproperty
  a_join_bad: assert property (p_join_bad) else $error("join on invalid pin code");

endmodule

`default_nettype wire

/* testbench/pocc_switch_model.sv */
// model of the port power switch and over-current sense side of the block
// assumes the bench commands faults and pulses; the shared port3 pin has a pull-up
`timescale 1ns/1ps
`default_nettype none

module pocc_switch_model (
  input  wire logic [2:0]        oc_fault,
  input  wire logic [2:0]        oc_gpio,
  input  wire logic [2:0]        cdp_pulse,
  input  wire logic              port3_fault,
  input  wire logic              port3_power_out,
  input  wire logic              port3_power_oe,
  output pocc_pkg::pocc_sense_t  sense,
  output logic                   port3_power_in
);
  // ------------------------------------------------------------
  // sense pins
  // ------------------------------------------------------------
  // dedicated pins, gpio sense and handshake pulses, port1 in bit 0
  assign sense = {oc_fault, oc_gpio, cdp_pulse};

  // shared pin: pull-up when released, switch flag pulls it low on fault
  assign port3_power_in = (port3_power_oe ? port3_power_out : 1'b1) & ~port3_fault;
endmodule

`default_nettype wire

/* testbench/port_power_overcurrent_config_tb_top.sv */
// self-checking bench for the port power / over-current configuration block
// assumes apb access with one wait state and registered pin outputs
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end

module port_power_overcurrent_config_tb_top;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [16:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        usb2, usb3, gpio, p3_fault, p3_in, p3_out, p3_oe, p3_on, p3_fix;
  logic        j_oc, j_valid, irq, er;
  logic [2:0]  oc_fault, oc_gpio, cdp, p_oc, p_dis;
  logic [5:0]  j_pin;
  pocc_pkg::pocc_sense_t sense;
  int          miscompares = 0;
  int          checks = 0;
  logic [3:0]  pcodes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9};
  logic [3:0]  ocodes [5] = '{4'h0, 4'h1, 4'h2, 4'hf, 4'h6};

  pocc_regs pocc_regs_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usb2_power_on(usb2), .usb3_power_on(usb3), .power_gpio(gpio),
    .sense(sense), .port3_power_in(p3_in), .port3_power_out(p3_out),
    .port3_power_oe(p3_oe), .port3_power_on(p3_on), .port3_fixed_device(p3_fix),
    .port_overcurrent(p_oc), .port_disabled(p_dis), .joined_overcurrent(j_oc),
    .joined_valid(j_valid), .joined_pin(j_pin), .irq(irq));

  pocc_switch_model pocc_switch_model_inst (.oc_fault(oc_fault), .oc_gpio(oc_gpio),
    .cdp_pulse(cdp), .port3_fault(p3_fault), .port3_power_out(p3_out),
    .port3_power_oe(p3_oe), .sense(sense), .port3_power_in(p3_in));

  // ------------------------------------------------------------
  // clock, verdict and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge clk);
    miscompares++;
    summarize();
  end

  // ------------------------------------------------------------
  // apb access and helpers
  // ------------------------------------------------------------
  // one transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [14:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [14:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, rd, er);
    `CHK("write_err", 1'b0, er)
  endtask

  task automatic rdchk(input string nm, input logic [14:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0, rd, er);
    `CHK(nm, e, rd)
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  function automatic logic pexp(input logic [3:0] c, input logic [2:0] k);
    case (c)
      pocc_pkg::PWR_USB2:   return k[2];
      pocc_pkg::PWR_USB3:   return k[1];
      pocc_pkg::PWR_EITHER: return k[2] | k[1];
      pocc_pkg::PWR_GPIO:   return k[0];
      default:              return 1'b0;
    endcase
  endfunction

  function automatic logic oexp(input logic [3:0] c, input logic [1:0] k);
    case (c)
      pocc_pkg::OC_PIN:   return k[0];
      pocc_pkg::OC_GPIO:  return k[1];
      pocc_pkg::OC_FORCE: return 1'b1;
      default:            return 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {resetn, psel, penable, pwrite, usb2, usb3, gpio, p3_fault} = 8'h00;
    {paddr, pwdata, oc_fault, oc_gpio, cdp} = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    settle();
    `CHK("disabled_rst", 3'b111, p_dis)
    rdchk("pwr3_rst", pocc_pkg::IDX_PWR3, 32'h0);
    rdchk("pin_rst", pocc_pkg::IDX_PIN, 32'h1);
    // unmapped place refuses and reads zero
    apb(1'b1, 15'h0001, 32'h5a, rd, er);
    `CHK("unmapped_err", 1'b1, er)
    apb(1'b0, 15'h0001, 32'h0, rd, er);
    `CHK("unmapped_rd", 32'h0, rd)
    // flag bits, reserved bit 6 reads zero
    wr(pocc_pkg::IDX_OVC3, 32'h1);
    wr(pocc_pkg::IDX_PWR3, 32'hffffffff);
    rdchk("pwr3_rw", pocc_pkg::IDX_PWR3, 32'hbf);
    settle();
    `CHK("fixed_dev", 1'b1, p3_fix)
    `CHK("disabled3", 1'b1, p_dis[2])
    // a disabled port stays unpowered even with a live source
    {usb2, usb3, gpio} <= 3'b111;
    wr(pocc_pkg::IDX_PWR3, 32'h23);
    settle();
    `CHK("disabled_power", 1'b0, p3_on)
    // each defined power code and reserved code 9 against every input pattern
    foreach (pcodes[i]) begin
      wr(pocc_pkg::IDX_PWR3, {28'h0, pcodes[i]});
      for (int k = 0; k < 8; k++) begin
        {usb2, usb3, gpio} <= 3'(k);
        settle();
        `CHK("power_on", pexp(pcodes[i], 3'(k)), p3_on)
        `CHK("power_out", pexp(pcodes[i], 3'(k)), p3_out)
        `CHK("power_oe", 1'b1, p3_oe)
      end
    end
    // combined mode shares the pin for power and fault
    wr(pocc_pkg::IDX_PWR3, 32'h81);
    usb2 <= 1'b1;
    settle();
    `CHK("comb_oe_on", 1'b0, p3_oe)
    p3_fault <= 1'b1;
    settle();
    `CHK("comb_fault", 1'b1, p_oc[2])
    usb2 <= 1'b0;
    settle();
    `CHK("comb_oe_off", 2'b10, {p3_oe, p3_out})
    wr(pocc_pkg::IDX_PWR3, 32'h1);
    settle();
    `CHK("sep_fault", 1'b0, p_oc[2])
    p3_fault <= 1'b0;
    // each defined over-current code and reserved code 6 on every port
    for (int p = 0; p < 3; p++) begin
      foreach (ocodes[i]) begin
        wr(pocc_pkg::IDX_OVC1 + 15'(4 * p), {28'h0, ocodes[i]});
        for (int k = 0; k < 4; k++) begin
          oc_fault <= {3{k[0]}};
          oc_gpio  <= {3{k[1]}};
          settle();
          `CHK("oc_source", oexp(ocodes[i], 2'(k)), p_oc[p])
          `CHK("oc_disable", ocodes[i] == 4'h0 || ocodes[i] == 4'h6, p_dis[p])
        end
      end
      wr(pocc_pkg::IDX_OVC1 + 15'(4 * p), 32'h1);
    end
    // rising over-current raises status, mask gates the interrupt
    {oc_fault, oc_gpio} <= 6'h00;
    settle();
    wr(pocc_pkg::IDX_STAT, 32'h3f);
    wr(pocc_pkg::IDX_MASK, 32'h3f);
    oc_fault <= 3'b010;
    settle();
    rdchk("stat_oc", pocc_pkg::IDX_STAT, 32'h2);
    `CHK("irq_set", 1'b1, irq)
    wr(pocc_pkg::IDX_MASK, 32'h0);
    settle();
    `CHK("irq_masked", 1'b0, irq)
    wr(pocc_pkg::IDX_MASK, 32'h3f);
    wr(pocc_pkg::IDX_STAT, 32'h2);
    settle();
    `CHK("irq_clear", 1'b0, irq)
    // handshake pulses set flags and status
    for (int p = 0; p < 3; p++) begin
      cdp <= 3'(1 << p);
      @(posedge clk);
      cdp <= 3'b000;
      settle();
      rdchk("cdp_flag", pocc_pkg::IDX_CDP, 32'((2 << p) - 1));
      rdchk("cdp_stat", pocc_pkg::IDX_STAT, 32'(((2 << p) - 1) << 3));
      `CHK("irq_cdp", 1'b1, irq)
    end
    wr(pocc_pkg::IDX_CDP, 32'h0);
    rdchk("cdp_clr", pocc_pkg::IDX_CDP, 32'h0);
    wr(pocc_pkg::IDX_STAT, 32'h38);
    // shared pin choice codes
    for (int c = 0; c < 17; c++) begin
      wr(pocc_pkg::IDX_PIN, 32'(c));
      settle();
      `CHK("pin_valid", c inside {0, 1, 3, 4, 5, 6, 7, 8, 9, 10, 15}, j_valid)
      `CHK("pin_code", 6'(c), j_pin)
    end
    // each join bit carries only its own port
    wr(pocc_pkg::IDX_PIN, 32'h1);
    for (int p = 0; p < 3; p++) begin
      wr(pocc_pkg::IDX_GANG, 32'(2 << p));
      oc_fault <= 3'(1 << p);
      settle();
      `CHK("joined_on", 1'b1, j_oc)
      oc_fault <= ~3'(1 << p);
      settle();
      `CHK("joined_off", 1'b0, j_oc)
    end
    oc_fault <= 3'b111;
    wr(pocc_pkg::IDX_PIN, 32'h2);
    settle();
    `CHK("joined_bad_pin", 1'b0, j_oc)
    summarize();
  end
endmodule

`default_nettype wire
